/* rtl/pcr_pkg.sv */
// constants and types of the picture-in-picture control register bank
//
// Behaviour
// - writes use bus address 26h, reads use 27h.
// - a read returns the status byte, repeated while the host acks; only two bits carry status.
// - status D7 reads 0 once the last written value is applied.
// - status D1 reads 0 while inset line pulses are present and locked.
// - register 00h D0-D2 places the inset start and black-level gate.
// - register 00h D4-D7 places the main picture clamp gate.
// - both gates can be watched on the test pin via register 03h.
// - register 01h D0-D3 delays the inset switch-on instant.
// - register 01h D4 turns on the three-line weighted vertical filter.
// - register 02h D0-D2 picks the border colour; 010 and 011 mean none.
// - register 03h D0-D2 picks the test pin signal and test counter mode.
// - test codes 000/001 make the pin an input, 010-111 internal outputs.
// - register 03h D6/D7 set main vertical/horizontal polarity, 1 negative.
package pcr_pkg;
    // ==================================================================
    // bus addresses and register map
    localparam logic [7:0] WR_ADDR = 8'h26;
    localparam logic [7:0] RD_ADDR = 8'h27;
    localparam logic [1:0] REG_GATE = 2'h0;
    localparam logic [1:0] REG_DELAY = 2'h1;
    localparam logic [1:0] REG_BORDER = 2'h2;
    localparam logic [1:0] REG_TEST = 2'h3;
    localparam logic [7:0] REG_LAST = 8'h03;
    localparam logic [7:0] REG_RESET = 8'h00;
    // ==================================================================
    // field positions
    localparam int ST_PEND_BIT = 7;
    localparam int ST_SYNC_BIT = 1;
    localparam int INSET_POS_LSB = 0;
    localparam int CLAMP_POS_LSB = 4;
    localparam int DELAY_LSB = 0;
    localparam int FILTER_BIT = 4;
    localparam int BORDER_LSB = 0;
    localparam int TSEL_LSB = 0;
    localparam int VPOL_BIT = 6;
    localparam int HPOL_BIT = 7;
    localparam logic [2:0] BC_NONE_A = 3'h2;
    localparam logic [2:0] BC_NONE_B = 3'h3;
    typedef enum logic [2:0] {
        TS_ANALOG = 3'h0, TS_DIGITAL = 3'h1, TS_SYNC = 3'h2,
        TS_SWITCH = 3'h3, TS_HDET = 3'h4, TS_VDET = 3'h5,
        TS_ICLAMP = 3'h6, TS_MCLAMP = 3'h7
    } pcr_tsel_t;
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0, ST_ADDR = 4'h1, ST_AACK_W = 4'h2, ST_SUB = 4'h3,
        ST_SACK = 4'h4, ST_DATA = 4'h5, ST_DACK = 4'h6, ST_AACK_R = 4'h7,
        ST_RD = 4'h8, ST_RACK = 4'h9
    } pcr_state_t;
    // ==================================================================
    // timing, ns and derived cycles
    localparam int CLK_NS = 50;
    localparam int INSET_CLK_NS = 6;
    localparam int INSET_SPAN_NS = 3000;
    localparam int INSET_STEPS = 7;
    localparam int CLAMP_SPAN_NS = 5000;
    localparam int CLAMP_STEPS = 15;
    localparam int INSET_BASE_NS = 1000;
    localparam int CLAMP_BASE_NS = 500;
    localparam int GATE_NS = 1000;
    localparam int SWITCH_STEP_NS = 100;
    localparam int INSET_WIN_NS = 15000;
    localparam int LINE_MIN_NS = 61981;
    localparam int LINE_MAX_NS = 65214;
    localparam logic [11:0] INSET_STEP_CYC =
        12'(INSET_SPAN_NS / INSET_STEPS / CLK_NS);
    localparam logic [11:0] CLAMP_STEP_CYC =
        12'(CLAMP_SPAN_NS / CLAMP_STEPS / CLK_NS);
    localparam logic [11:0] INSET_BASE_CYC = 12'(INSET_BASE_NS / CLK_NS);
    localparam logic [11:0] CLAMP_BASE_CYC = 12'(CLAMP_BASE_NS / CLK_NS);
    localparam logic [11:0] GATE_CYC = 12'((GATE_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [11:0] SWITCH_STEP_CYC = 12'(SWITCH_STEP_NS / CLK_NS);
    localparam logic [11:0] INSET_WIN_CYC = 12'(INSET_WIN_NS / CLK_NS);
    localparam int LOCK_MIN_DEF =
        (LINE_MIN_NS + INSET_CLK_NS - 1) / INSET_CLK_NS;
    localparam int LOCK_MAX_DEF = LINE_MAX_NS / INSET_CLK_NS;
endpackage

/* rtl/pcr_top.sv */
// register bank, two-wire slave and gate timing of the pip controller
`timescale 1ns/1ps
`default_nettype none
module pcr_top #(
    parameter int LOCK_MIN_CYC = pcr_pkg::LOCK_MIN_DEF,
    parameter int LOCK_MAX_CYC = pcr_pkg::LOCK_MAX_DEF
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic main_hsync,
    input wire logic main_vsync,
    input wire logic inset_clk,
    input wire logic inset_hsync,
    input wire logic inset_vsync,
    input wire logic test_pin_in,
    output logic test_pin_out,
    output logic test_pin_oe,
    output logic inset_gate,
    output logic main_clamp_gate,
    output logic inset_switch,
    output logic [2:0] border_colour_code,
    output logic border_on,
    output logic three_line_filter_on,
    output logic [7:0] test_addr
);
    // ==================================================================
    // elaboration check
    if (LOCK_MIN_CYC < 1 || LOCK_MAX_CYC <= LOCK_MIN_CYC ||
        LOCK_MAX_CYC > 65534) begin : g_bad_lock
        $error("lock window parameters out of range");
    end

    // ==================================================================
    // pin synchronisers
    logic [1:0] scl_s_q, sda_s_q, mh_s_q, mv_s_q, ih_s_q, iv_s_q, tp_s_q;
    logic [1:0] lock_s_q, ack_s_q;
    logic scl_p_q, sda_p_q;
    logic lock_q, ack_q;
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            scl_s_q <= 2'h3;
            sda_s_q <= 2'h3;
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
            mh_s_q <= 2'h0;
            mv_s_q <= 2'h0;
            ih_s_q <= 2'h0;
            iv_s_q <= 2'h0;
            tp_s_q <= 2'h0;
            lock_s_q <= 2'h0;
            ack_s_q <= 2'h0;
        end else if (ce) begin
            scl_s_q <= {scl_s_q[0], scl_in};
            sda_s_q <= {sda_s_q[0], sda_in};
            scl_p_q <= scl_s_q[1];
            sda_p_q <= sda_s_q[1];
            mh_s_q <= {mh_s_q[0], main_hsync};
            mv_s_q <= {mv_s_q[0], main_vsync};
            ih_s_q <= {ih_s_q[0], inset_hsync};
            iv_s_q <= {iv_s_q[0], inset_vsync};
            tp_s_q <= {tp_s_q[0], test_pin_in};
            lock_s_q <= {lock_s_q[0], lock_q};
            ack_s_q <= {ack_s_q[0], ack_q};
        end
    end

    logic scl_rise, scl_fall, bus_start, bus_stop;
    assign scl_rise = ce & scl_s_q[1] & ~scl_p_q;
    assign scl_fall = ce & ~scl_s_q[1] & scl_p_q;
    assign bus_start = ce & scl_s_q[1] & scl_p_q & sda_p_q & ~sda_s_q[1];
    assign bus_stop = ce & scl_s_q[1] & scl_p_q & ~sda_p_q & sda_s_q[1];

    // ==================================================================
    // two-wire slave
    pcr_pkg::pcr_state_t st_q;
    logic [3:0] cnt_q;
    logic [7:0] sh_q, sub_q, status_w;
    logic sda_oe_q, mack_q, pend_q, req_q, wr_stb;
    logic [7:0] regs_q [0:3];

    always_comb begin
        status_w = 8'h00;
        status_w[pcr_pkg::ST_PEND_BIT] = pend_q;
        status_w[pcr_pkg::ST_SYNC_BIT] = ~lock_s_q[1];
    end

    assign wr_stb = scl_fall & ~bus_start & ~bus_stop &
        (st_q == pcr_pkg::ST_DATA) & (cnt_q == 4'h8);

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            st_q <= pcr_pkg::ST_IDLE;
            cnt_q <= 4'h0;
            sh_q <= 8'h00;
            sub_q <= 8'h00;
            sda_oe_q <= 1'b0;
            mack_q <= 1'b0;
        end else if (bus_start) begin
            st_q <= pcr_pkg::ST_ADDR;
            cnt_q <= 4'h0;
            sda_oe_q <= 1'b0;
        end else if (bus_stop) begin
            st_q <= pcr_pkg::ST_IDLE;
            sda_oe_q <= 1'b0;
        end else if (scl_rise) begin
            case (st_q)
                pcr_pkg::ST_ADDR, pcr_pkg::ST_SUB, pcr_pkg::ST_DATA: begin
                    sh_q <= {sh_q[6:0], sda_s_q[1]};
                    cnt_q <= cnt_q + 4'h1;
                end
                pcr_pkg::ST_RD: cnt_q <= cnt_q + 4'h1;
                pcr_pkg::ST_RACK: mack_q <= ~sda_s_q[1];
                default: ;
            endcase
        end else if (scl_fall) begin
            case (st_q)
                pcr_pkg::ST_ADDR: if (cnt_q == 4'h8) begin
                    if (sh_q == pcr_pkg::WR_ADDR) begin
                        st_q <= pcr_pkg::ST_AACK_W;
                        sda_oe_q <= 1'b1;
                    end else if (sh_q == pcr_pkg::RD_ADDR) begin
                        st_q <= pcr_pkg::ST_AACK_R;
                        sda_oe_q <= 1'b1;
                    end else begin
                        st_q <= pcr_pkg::ST_IDLE;
                    end
                end
                pcr_pkg::ST_AACK_W: begin
                    sda_oe_q <= 1'b0;
                    cnt_q <= 4'h0;
                    st_q <= pcr_pkg::ST_SUB;
                end
                pcr_pkg::ST_SUB: if (cnt_q == 4'h8) begin
                    sub_q <= sh_q;
                    // higher sub-addresses belong to other blocks
                    if (sh_q <= pcr_pkg::REG_LAST) begin
                        sda_oe_q <= 1'b1;
                        st_q <= pcr_pkg::ST_SACK;
                    end else begin
                        st_q <= pcr_pkg::ST_IDLE;
                    end
                end
                pcr_pkg::ST_SACK: begin
                    sda_oe_q <= 1'b0;
                    cnt_q <= 4'h0;
                    st_q <= pcr_pkg::ST_DATA;
                end
                pcr_pkg::ST_DATA: if (cnt_q == 4'h8) begin
                    sda_oe_q <= 1'b1;
                    st_q <= pcr_pkg::ST_DACK;
                end
                pcr_pkg::ST_DACK: begin
                    // one data byte per write; later bytes go unanswered
                    sda_oe_q <= 1'b0;
                    st_q <= pcr_pkg::ST_IDLE;
                end
                pcr_pkg::ST_AACK_R, pcr_pkg::ST_RACK: begin
                    if (st_q == pcr_pkg::ST_AACK_R || mack_q) begin
                        sh_q <= status_w;
                        sda_oe_q <= ~status_w[7];
                        cnt_q <= 4'h0;
                        st_q <= pcr_pkg::ST_RD;
                    end else begin
                        sda_oe_q <= 1'b0;
                        st_q <= pcr_pkg::ST_IDLE;
                    end
                end
                pcr_pkg::ST_RD: if (cnt_q == 4'h8) begin
                    sda_oe_q <= 1'b0;
                    st_q <= pcr_pkg::ST_RACK;
                end else begin
                    sh_q <= {sh_q[6:0], 1'b0};
                    sda_oe_q <= ~sh_q[6];
                end
                default: st_q <= pcr_pkg::ST_IDLE;
            endcase
        end
    end
    assign sda_out = 1'b0;
    assign sda_oe = sda_oe_q;

    // ==================================================================
    // registers and write completion
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            for (int i = 0; i < 4; i++) regs_q[i] <= pcr_pkg::REG_RESET;
        end else if (wr_stb) begin
            regs_q[sub_q[1:0]] <= sh_q;
        end
    end

    // toggle handshake: done only once the inset side has seen the write
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            req_q <= 1'b0;
            pend_q <= 1'b0;
        end else if (wr_stb) begin
            req_q <= ~req_q;
            pend_q <= 1'b1;
        end else if (ce && ack_s_q[1] == req_q) begin
            pend_q <= 1'b0;
        end
    end

    // ==================================================================
    // line timing and gates
    logic [2:0] inset_pos;
    logic [3:0] clamp_pos, delay_w;
    logic [11:0] line_q, inset_start_w, clamp_start_w, switch_start_w;
    logic mh_lvl, mv_lvl, mh_p_q;
    logic inset_gate_q, main_clamp_q, inset_switch_q;
    pcr_pkg::pcr_tsel_t tsel;

    function automatic logic in_win(input logic [11:0] c, s, len);
        return (c >= s) && (c < s + len);
    endfunction

    assign inset_pos = regs_q[pcr_pkg::REG_GATE][pcr_pkg::INSET_POS_LSB +: 3];
    assign clamp_pos = regs_q[pcr_pkg::REG_GATE][pcr_pkg::CLAMP_POS_LSB +: 4];
    assign delay_w = regs_q[pcr_pkg::REG_DELAY][pcr_pkg::DELAY_LSB +: 4];
    assign tsel = pcr_pkg::pcr_tsel_t'(
        regs_q[pcr_pkg::REG_TEST][pcr_pkg::TSEL_LSB +: 3]);
    assign mh_lvl = mh_s_q[1] ^ regs_q[pcr_pkg::REG_TEST][pcr_pkg::HPOL_BIT];
    assign mv_lvl = mv_s_q[1] ^ regs_q[pcr_pkg::REG_TEST][pcr_pkg::VPOL_BIT];
    assign inset_start_w = pcr_pkg::INSET_BASE_CYC +
        12'(inset_pos) * pcr_pkg::INSET_STEP_CYC;
    assign clamp_start_w = pcr_pkg::CLAMP_BASE_CYC +
        12'(clamp_pos) * pcr_pkg::CLAMP_STEP_CYC;
    // all four delay bits step the switch-on instant
    assign switch_start_w = inset_start_w +
        12'(delay_w) * pcr_pkg::SWITCH_STEP_CYC;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            mh_p_q <= 1'b0;
            line_q <= 12'h000;
        end else if (ce) begin
            mh_p_q <= mh_lvl;
            if (mh_lvl && !mh_p_q) line_q <= 12'h000;
            else if (line_q != 12'hfff) line_q <= line_q + 12'h001;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            inset_gate_q <= 1'b0;
            main_clamp_q <= 1'b0;
            inset_switch_q <= 1'b0;
        end else if (ce) begin
            inset_gate_q <= in_win(line_q, inset_start_w, pcr_pkg::GATE_CYC);
            // no clamping of main black level during vertical sync
            main_clamp_q <= in_win(line_q, clamp_start_w, pcr_pkg::GATE_CYC)
                & ~mv_lvl;
            inset_switch_q <= in_win(line_q, switch_start_w,
                pcr_pkg::INSET_WIN_CYC);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            border_colour_code <= 3'h0;
            border_on <= 1'b0;
        end else if (ce) begin
            border_colour_code <=
                regs_q[pcr_pkg::REG_BORDER][pcr_pkg::BORDER_LSB +: 3];
            border_on <= !(regs_q[pcr_pkg::REG_BORDER][2:0] inside
                {pcr_pkg::BC_NONE_A, pcr_pkg::BC_NONE_B});
        end
    end

    // ==================================================================
    // test pin and test address counter
    logic tp_p_q;
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            test_pin_out <= 1'b0;
            test_pin_oe <= 1'b0;
        end else if (ce) begin
            test_pin_oe <= (tsel != pcr_pkg::TS_ANALOG) &&
                (tsel != pcr_pkg::TS_DIGITAL);
            case (tsel)
                pcr_pkg::TS_SYNC: test_pin_out <= lock_s_q[1];
                pcr_pkg::TS_SWITCH: test_pin_out <= inset_switch_q;
                pcr_pkg::TS_HDET: test_pin_out <= ih_s_q[1];
                pcr_pkg::TS_VDET: test_pin_out <= iv_s_q[1];
                pcr_pkg::TS_ICLAMP: test_pin_out <= inset_gate_q;
                pcr_pkg::TS_MCLAMP: test_pin_out <= main_clamp_q;
                default: test_pin_out <= 1'b0;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            tp_p_q <= 1'b0;
            test_addr <= 8'h00;
        end else if (ce) begin
            tp_p_q <= tp_s_q[1];
            if (tsel != pcr_pkg::TS_DIGITAL) test_addr <= 8'h00;
            else if (tp_s_q[1] && !tp_p_q) test_addr <= test_addr + 8'h01;
        end
    end

    // ==================================================================
    // inset clock domain: line lock, write acknowledge, filter
    logic [1:0] irst_s_q, ice_s_q, ihs_q, req_s_q, filt_s_q;
    logic ih_p_q;
    logic [15:0] per_q;
    always_ff @(posedge inset_clk) begin
        irst_s_q <= {irst_s_q[0], srst};
        ice_s_q <= {ice_s_q[0], ce};
    end
    always_ff @(posedge inset_clk) begin
        if (irst_s_q[1]) begin
            ihs_q <= 2'h0;
            req_s_q <= 2'h0;
            filt_s_q <= 2'h0;
            ih_p_q <= 1'b0;
            per_q <= 16'h0000;
            lock_q <= 1'b0;
            ack_q <= 1'b0;
            three_line_filter_on <= 1'b0;
        end else if (ice_s_q[1]) begin
            ihs_q <= {ihs_q[0], inset_hsync};
            req_s_q <= {req_s_q[0], req_q};
            filt_s_q <= {filt_s_q[0],
                regs_q[pcr_pkg::REG_DELAY][pcr_pkg::FILTER_BIT]};
            ih_p_q <= ihs_q[1];
            ack_q <= req_s_q[1];
            three_line_filter_on <= filt_s_q[1];
            if (ihs_q[1] && !ih_p_q) begin
                per_q <= 16'h0000;
                lock_q <= (per_q >= 16'(LOCK_MIN_CYC)) &&
                    (per_q <= 16'(LOCK_MAX_CYC));
            end else if (per_q > 16'(LOCK_MAX_CYC)) begin
                lock_q <= 1'b0;
            end else begin
                per_q <= per_q + 16'h0001;
            end
        end
    end
    assign inset_gate = inset_gate_q;
    assign main_clamp_gate = main_clamp_q;
    assign inset_switch = inset_switch_q;

    // ==================================================================
    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    sequence s_addr_done;
        scl_fall && !bus_start && !bus_stop && st_q == pcr_pkg::ST_ADDR &&
            cnt_q == 4'h8;
    endsequence
    sequence s_read_load;
        scl_fall && !bus_start && !bus_stop && st_q == pcr_pkg::ST_AACK_R;
    endsequence
    chk_write_addr: assert property ((s_addr_done ##0 sh_q == pcr_pkg::WR_ADDR) |=> st_q == pcr_pkg::ST_AACK_W && sda_oe_q) else $error("write address not acknowledged");
    chk_read_addr: assert property ((s_addr_done ##0 sh_q == pcr_pkg::RD_ADDR) |=> st_q == pcr_pkg::ST_AACK_R && sda_oe_q) else $error("read address not acknowledged");
    chk_status_byte: assert property (s_read_load |=> sh_q[6:2] == 5'h00 && !sh_q[0] && sh_q[7] == $past(pend_q) && sh_q[1] == !$past(lock_s_q[1])) else $error("status byte wrong");
    chk_pend_set: assert property (wr_stb |=> pend_q) else $error("pending flag not set by write");
    chk_pend_clear: assert property (wr_stb ##1 (ce && !wr_stb && !srst)[*8] ##0 ack_s_q[1] == req_q |=> !pend_q) else $error("pending flag stuck");
    chk_store_byte: assert property (wr_stb |=> regs_q[$past(sub_q[1:0])] == $past(sh_q)) else $error("data byte not stored");
    chk_inset_gate: assert property (ce && line_q == pcr_pkg::INSET_BASE_CYC + 12'(inset_pos) * pcr_pkg::INSET_STEP_CYC |=> inset_gate_q) else $error("inset gate misplaced");
    chk_clamp_gate: assert property (ce && !mv_lvl && line_q == clamp_start_w |=> main_clamp_q ##1 (!ce || main_clamp_q || line_q == 12'h000 || $past(mv_lvl))) else $error("clamp gate misplaced");
    chk_test_mux: assert property (ce && tsel == pcr_pkg::TS_ICLAMP |=> test_pin_oe && test_pin_out == $past(inset_gate_q)) else $error("test pin not showing gate");
    chk_test_input: assert property (ce && (tsel == pcr_pkg::TS_ANALOG || tsel == pcr_pkg::TS_DIGITAL) |=> !test_pin_oe) else $error("test pin driven in input mode");
    chk_border_off: assert property (ce && regs_q[pcr_pkg::REG_BORDER][2:1] == 2'h1 |=> !border_on) else $error("border shown for no-border code");
endmodule // pcr_top
`default_nettype wire

/* test/pcr_host.sv */
// two-wire bus host model for the pip control register bank
`timescale 1ns/1ps
`default_nettype none
module pcr_host (
    input wire logic ref_clk,
    input wire logic sda_wire,
    output logic scl,
    output logic sda_m
);
    // ====
    // bit timing
    // 8-cycle scl phases; sda moves mid-low, clear of both scl edges
    initial begin
        scl = 1'b1;
        sda_m = 1'b1;
    end
    task automatic wt(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic bit_io(input logic b, output logic r);
        wt(4);
        sda_m = b;
        wt(4);
        scl = 1'b1;
        wt(4);
        r = sda_wire;
        wt(4);
        scl = 1'b0;
    endtask
    task automatic byte_io(input logic [7:0] d, input logic last,
        output logic [7:0] r, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r[i]);
        end
        bit_io(last, a);
        ack = ~a;
    endtask
    // ====
    // framing
    task automatic start();
        wt(1);
        sda_m = 1'b0;
        wt(8);
        scl = 1'b0;
    endtask
    task automatic stop();
        wt(4);
        sda_m = 1'b0;
        wt(4);
        scl = 1'b1;
        wt(8);
        sda_m = 1'b1;
        wt(8);
    endtask
    // ====
    // transfers
    task automatic wr_reg(input logic [7:0] adr, sub, d, output logic ok);
        logic [7:0] r;
        logic a0, a1, a2;
        start();
        byte_io(adr, 1'b1, r, a0);
        byte_io(sub, 1'b1, r, a1);
        byte_io(d, 1'b1, r, a2);
        stop();
        ok = a0 & a1 & a2;
    endtask
    // nack after the single byte ends the read
    task automatic rd_stat(output logic [7:0] st, output logic ok);
        logic [7:0] r;
        logic a;
        start();
        byte_io(pcr_pkg::RD_ADDR, 1'b1, r, ok);
        byte_io(8'hff, 1'b1, st, a);
        stop();
    endtask
endmodule // pcr_host
`default_nettype wire

/* test/pcr_top_bench.sv */
// self-checking bench for the pip control register bank
`timescale 1ns/1ps
`default_nettype none
module pcr_top_bench;
    logic ref_clk = 1'b0;
    logic inset_clk = 1'b0;
    logic iclk_run = 1'b1;
    logic srst = 1'b1;
    logic hs_run = 1'b0;
    logic main_hsync = 1'b0;
    logic main_vsync = 1'b0;
    logic inset_hsync = 1'b0;
    logic inset_vsync = 1'b0;
    logic test_pin_in = 1'b0;
    logic scl, sda_m, sda_out, sda_oe, pin_out, pin_oe, filt;
    logic inset_gate, clamp_gate, inset_switch, border_on, ok;
    logic [2:0] bcode;
    logic [7:0] test_addr, st;
    int hcnt = 0;
    int err_count = 0;
    int total_checks = 0;
    wire sda_wire = sda_m & ~sda_oe;
    pcr_host u_host (.ref_clk(ref_clk), .sda_wire(sda_wire), .scl(scl),
        .sda_m(sda_m));
    pcr_top #(.LOCK_MIN_CYC(20), .LOCK_MAX_CYC(40)) u_dut (
        .ref_clk(ref_clk), .srst(srst), .ce(1'b1), .scl_in(scl),
        .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe),
        .main_hsync(main_hsync), .main_vsync(main_vsync),
        .inset_clk(inset_clk), .inset_hsync(inset_hsync),
        .inset_vsync(inset_vsync), .test_pin_in(test_pin_in),
        .test_pin_out(pin_out), .test_pin_oe(pin_oe),
        .inset_gate(inset_gate), .main_clamp_gate(clamp_gate),
        .inset_switch(inset_switch), .border_colour_code(bcode),
        .border_on(border_on), .three_line_filter_on(filt),
        .test_addr(test_addr));
    // ====
    // clocks and inset lines
    always #25 ref_clk = ~ref_clk;
    always #3 if (iclk_run) inset_clk = ~inset_clk;
    // 30-cycle line period sits inside the shortened lock window
    always @(posedge inset_clk) begin
        hcnt <= (hcnt == 29) ? 0 : hcnt + 1;
        inset_hsync <= hs_run && hcnt < 2;
    end
    // ====
    // helpers
    task automatic check(input string what, input logic [7:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic wr(input logic [7:0] sub, d);
        u_host.wr_reg(pcr_pkg::WR_ADDR, sub, d, ok);
        check("write ack", 8'(ok), 8'h01);
        wt(4);
    endtask
    task automatic rd();
        u_host.rd_stat(st, ok);
        check("read ack", 8'(ok), 8'h01);
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // ====
    // scenarios
    task automatic t_border();
        for (int c = 0; c < 8; c++) begin
            wr(8'h02, 8'(c));
            check("border code", 8'(bcode), 8'(c));
            check("border on", 8'(border_on), 8'(c != 2 && c != 3));
        end
        wr(8'h01, 8'h10);
        check("filter on", 8'(filt), 8'h01);
        wr(8'h01, 8'h0f);
        check("filter off", 8'(filt), 8'h00);
        u_host.wr_reg(8'h30, 8'h02, 8'h05, ok);
        check("foreign address", 8'(ok), 8'h00);
        u_host.wr_reg(pcr_pkg::WR_ADDR, 8'h04, 8'h05, ok);
        check("sub-address 04h", 8'(ok), 8'h00);
        check("border kept", 8'(bcode), 8'h07);
        $display("register writes done");
    endtask
    task automatic t_pin();
        wr(8'h03, 8'h00);
        check("pin dir 000", 8'(pin_oe), 8'h00);
        wr(8'h03, 8'h01);
        check("pin dir 001", 8'(pin_oe), 8'h00);
        repeat (3) begin
            test_pin_in = 1'b1;
            wt(6);
            test_pin_in = 1'b0;
            wt(6);
        end
        check("test counter", test_addr, 8'h03);
        wr(8'h03, 8'h05);
        inset_vsync = 1'b1;
        wt(6);
        check("pin vdet high", 8'({pin_oe, pin_out}), 8'h03);
        check("counter cleared", test_addr, 8'h00);
        inset_vsync = 1'b0;
        wt(6);
        check("pin vdet low", 8'(pin_out), 8'h00);
        $display("test pin done");
    endtask
    task automatic t_status();
        iclk_run = 1'b0;
        wr(8'h03, 8'h02);
        rd();
        check("pending set", 8'(st[7]), 8'h01);
        iclk_run = 1'b1;
        wt(20);
        rd();
        check("pending clear", 8'(st[7]), 8'h00);
        hs_run = 1'b1;
        wt(100);
        rd();
        check("status locked", st, 8'h00);
        check("pin sync high", 8'({pin_oe, pin_out}), 8'h03);
        hs_run = 1'b0;
        wt(40);
        rd();
        check("status unlocked", st, 8'h02);
        check("pin sync low", 8'(pin_out), 8'h00);
        $display("status done");
    endtask
    // first rise of each gate after an active main line edge
    task automatic meas(input logic pol, output int g[4]);
        logic [3:0] v;
        g = '{default: -1};
        main_hsync = ~pol;
        for (int n = 0; n < 500; n++) begin
            @(negedge ref_clk);
            if (n == 4)
                main_hsync = pol;
            v = {pin_out, inset_switch, clamp_gate, inset_gate};
            for (int k = 0; k < 4; k++)
                if (v[k] === 1'b1 && g[k] < 0)
                    g[k] = n;
        end
    endtask
    task automatic t_gates();
        int a[4];
        int b[4];
        int c[4];
        int d[4];
        int si = pcr_pkg::INSET_STEP_CYC;
        int sc = pcr_pkg::CLAMP_STEP_CYC;
        int sw = pcr_pkg::SWITCH_STEP_CYC;
        wr(8'h03, 8'h06);
        wr(8'h00, 8'h00);
        wr(8'h01, 8'h00);
        meas(1'b0, a);
        meas(1'b0, a);
        wr(8'h00, 8'h32);
        wr(8'h01, 8'h05);
        meas(1'b0, b);
        meas(1'b0, b);
        main_hsync = 1'b1;
        wr(8'h03, 8'h87);
        meas(1'b1, c);
        meas(1'b1, c);
        // vertical reference inverted: idle low level now blocks the clamp
        wr(8'h03, 8'hc7);
        meas(1'b1, d);
        check("v polarity off", 8'(d[1]), 8'hff);
        main_vsync = 1'b1;
        meas(1'b1, d);
        check("v polarity on", 8'(d[1] - b[1]), 8'h00);
        check("inset step", 8'(b[0] - a[0]), 8'(2 * si));
        check("clamp step", 8'(b[1] - a[1]), 8'(3 * sc));
        check("switch step", 8'(b[2] - a[2]), 8'(2 * si + 5 * sw));
        check("pin gate", 8'(a[3] - a[0]), 8'h01);
        check("h polarity", 8'(c[0] - b[0]), 8'h00);
        check("pin clamp", 8'(c[3] - c[1]), 8'h01);
        $display("gates done");
    endtask
    // ====
    // main sequence and watchdog
    initial begin
        wt(8);
        srst = 1'b0;
        wt(4);
        rd();
        check("status after reset", st, 8'h02);
        t_border();
        t_pin();
        t_status();
        t_gates();
        close_out();
    end
    initial begin
        #3ms;
        err_count++;
        close_out();
    end
endmodule // pcr_top_bench
`default_nettype wire
